// ### src/ecpph_host.sv
`timescale 1ns/1ns
// Operation
// - Forward idle keeps host clock high; peripheral keeps its ack low.
// - A forward transfer starts only from forward idle; in FIFO mode later bytes start from ST_FF_REARM.
// - Peripheral may request reversal any time; host samples the request.
// - Forward byte: ack low, clock low, ack high, clock high, ack low.
// - Data and host-ack line valid up to 60 ns before clock falls.
// - Clock falls at least 80 ns, at most 200 ns, after ack falls.
// - Clock rises 80 to 180 ns after ack rises.
// - Data changes 80 to 180 ns after ack falls.
// - Ack input counts as changed only after 75 to 130 ns stable.
// - Reverse idle: peripheral clock high, host-ack low.
// - Reverse byte: ack low, pclk low, ack high, pclk high, ack low.
// - Host-ack rises 80 to 200 ns after pclk falls, or stalls low.
// - Host-ack falls 80 to 200 ns after pclk rises.
// - Peripheral clock counts as changed only after 75 to 130 ns stable.
// - Push-pull in extended mode, open-collector in compatible mode, glitch-free.
// - FIFO mode ignores the acknowledge line and paces on busy alone.
// - FIFO mode: data 600 ns before strobe, strobe active 600 ns.
// - FIFO mode: strobe again no sooner than 680 ns after busy falls.
// - FIFO mode: hold data after strobe until busy falls or 450 ns.
// - FIFO mode: data valid 80 ns after busy falls.
module ecpph_host
    import ecpph_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire ecpph_mode_t mode,
    input  wire logic        tx_valid,
    input  wire ecpph_byte_t tx_byte,
    output logic             tx_ready,
    input  wire logic        rev_req,
    input  wire logic        rx_room,
    input  wire logic        rx_tc,
    output logic             rx_valid,
    output logic [7:0]       rx_data,
    output logic             periph_req,
    input  wire logic        busy_in,
    input  wire logic        periph_clk_in,
    input  wire logic        periph_req_n_in,
    input  wire logic [7:0]  port_data_lines_in,
    output logic [7:0]       port_data_lines_out,
    output logic             port_data_lines_oe,
    output logic             host_clk_out,
    output logic             host_clk_oe,
    output logic             host_ack_line_out,
    output logic             host_ack_line_oe
);

    // Two-flop synchronisers for cable inputs; stage one feeds only stage two.
    logic [10:0] sync1;
    logic [10:0] sync2;
    always_ff @(posedge clk_sys) begin
        sync1 <= {periph_req_n_in, periph_clk_in, busy_in, port_data_lines_in};
        sync2 <= sync1;
    end

    // Glitch filters for busy and peripheral clock; one instance per line.
    logic [1:0] filt;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_filt
            logic             stable;
            logic [CNT_W-1:0] cnt;
            logic             next_stable;
            logic [CNT_W-1:0] next_cnt;
            always_comb begin
                next_stable = stable;
                next_cnt    = cnt;
                if (sync2[8 + g] == stable) begin
                    next_cnt = '0;
                end else if (cnt == CNT_W'(CYC_FILT - 1)) begin
                    next_stable = sync2[8 + g];
                    next_cnt    = '0;
                end else begin
                    next_cnt = cnt + CNT_W'(1);
                end
            end
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    stable <= (g == 1);
                    cnt    <= '0;
                end else begin
                    stable <= next_stable;
                    cnt    <= next_cnt;
                end
            end
            assign filt[g] = stable;
        end
    endgenerate

    wire busy_f = filt[0];
    wire pclk_f = filt[1];

    // Sequencer state and its timer.
    ecpph_state_t     state;
    ecpph_state_t     next_state;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] next_tmr;
    ecpph_byte_t      obyte;
    ecpph_byte_t      next_obyte;
    logic             hclk;
    logic             next_hclk;
    logic             hack;
    logic             next_hack;
    logic             drv_data;
    logic             next_drv_data;
    logic             next_tx_ready;
    logic             next_rx_valid;
    logic [7:0]       next_rx_data;
    logic             busy_prev;
    logic             pp_mode;

    // The timer counts up and holds at all ones; only the transitions that time a phase clear it.
    wire tmr_done_min80 = (tmr >= CNT_W'(CYC_MIN80));

    // Next-state logic for all phases.
    always_comb begin
        next_state    = state;
        next_tmr      = (tmr == '1) ? tmr : tmr + CNT_W'(1);
        next_obyte    = obyte;
        next_hclk     = hclk;
        next_hack     = hack;
        next_drv_data = drv_data;
        next_tx_ready = 1'b0;
        next_rx_valid = 1'b0;
        next_rx_data  = rx_data;
        case (state)
            ST_FWD_IDLE: begin
                next_hclk = 1'b1;
                if (mode == ECPPH_MODE_FIFO && tx_valid && !tx_ready) begin
                    next_obyte    = tx_byte;
                    next_tx_ready = 1'b1;
                    next_drv_data = 1'b1;
                    next_tmr      = '0;
                    next_state    = ST_FF_SETUP;
                end else if (mode == ECPPH_MODE_ECP && rev_req) begin
                    next_drv_data = 1'b0;
                    next_hack     = 1'b0;
                    next_state    = ST_REV_IDLE;
                end else if (mode == ECPPH_MODE_ECP && tx_valid && !tx_ready
                             && !busy_f && tmr_done_min80) begin
                    next_obyte    = tx_byte;
                    next_hack     = tx_byte.cmd;
                    next_tx_ready = 1'b1;
                    next_drv_data = 1'b1;
                    next_tmr      = '0;
                    next_state    = ST_FWD_SETUP;
                end
            end
            ST_FWD_SETUP: begin
                // Data settles one cycle (20 ns) before the clock falls.
                next_hclk  = 1'b0;
                next_tmr   = '0;
                next_state = ST_FWD_CLKLOW;
            end
            ST_FWD_CLKLOW: begin
                if (busy_f) begin
                    next_tmr   = '0;
                    next_state = ST_FWD_CLKHI;
                end
            end
            ST_FWD_CLKHI: begin
                if (tmr == CNT_W'(CYC_MIN80 - 1)) begin
                    next_hclk  = 1'b1;
                    next_state = ST_FWD_DRAIN;
                end
            end
            ST_FWD_DRAIN: begin
                if (!busy_f) begin
                    next_tmr   = '0;
                    next_state = ST_FWD_IDLE;
                end
            end
            ST_REV_IDLE: begin
                next_hack = 1'b0;
                if (!rev_req) begin
                    next_state = ST_FWD_IDLE;
                end else if (!pclk_f) begin
                    next_tmr   = '0;
                    next_state = ST_REV_WAIT;
                end
            end
            ST_REV_WAIT: begin
                if (tmr_done_min80 && rx_room && !rx_tc) begin
                    next_hack  = 1'b1;
                    next_state = ST_REV_ACKHI;
                end
            end
            ST_REV_ACKHI: begin
                if (pclk_f) begin
                    next_rx_data  = sync2[7:0];
                    next_rx_valid = 1'b1;
                    next_tmr      = '0;
                    next_state    = ST_REV_ACKLO;
                end
            end
            ST_REV_ACKLO: begin
                if (tmr == CNT_W'(CYC_MIN80 - 1)) begin
                    next_hack  = 1'b0;
                    next_state = ST_REV_IDLE;
                end
            end
            ST_FF_SETUP: begin
                if (tmr == CNT_W'(CYC_FIFO_SETUP - 1)) begin
                    next_hclk  = 1'b0;
                    next_tmr   = '0;
                    next_state = ST_FF_PULSE;
                end
            end
            ST_FF_PULSE: begin
                if (tmr == CNT_W'(CYC_FIFO_PULSE - 1)) begin
                    next_hclk  = 1'b1;
                    next_tmr   = '0;
                    next_state = ST_FF_HOLD;
                end
            end
            ST_FF_HOLD: begin
                // Acknowledge is ignored; busy alone paces the next byte.
                if (tmr >= CNT_W'(CYC_FIFO_HOLD) && !busy_f && busy_prev) begin
                    next_tmr   = '0;
                    next_state = ST_FF_REARM;
                end else if (tmr >= CNT_W'(CYC_FIFO_HOLD) && !busy_f) begin
                    next_tmr   = CNT_W'(CYC_FIFO_REARM);
                    next_state = ST_FF_REARM;
                end
            end
            ST_FF_REARM: begin
                if (busy_f) begin
                    next_state = ST_FF_HOLD;
                end else if (tmr >= CNT_W'(CYC_FIFO_DHOLD) && tx_valid && !tx_ready
                             && (tmr >= CNT_W'(CYC_FIFO_REARM - CYC_FIFO_SETUP))) begin
                    next_obyte    = tx_byte;
                    next_tx_ready = 1'b1;
                    next_tmr      = '0;
                    next_state    = ST_FF_SETUP;
                end else if (mode != ECPPH_MODE_FIFO) begin
                    next_state = ST_FWD_IDLE;
                end
            end
            default: begin
                next_state = ST_FWD_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state     <= ST_FWD_IDLE;
            tmr       <= '0;
            obyte     <= '0;
            hclk      <= RST_HOST_CLK;
            hack      <= RST_HOST_ACK;
            drv_data  <= 1'b0;
            tx_ready  <= 1'b0;
            rx_valid  <= 1'b0;
            rx_data   <= 8'h00;
            busy_prev <= 1'b0;
            pp_mode   <= 1'b0;
        end else begin
            state     <= next_state;
            tmr       <= next_tmr;
            obyte     <= next_obyte;
            hclk      <= next_hclk;
            hack      <= next_hack;
            drv_data  <= next_drv_data;
            tx_ready  <= next_tx_ready;
            rx_valid  <= next_rx_valid;
            rx_data   <= next_rx_data;
            busy_prev <= busy_f;
            // Driver type changes only in forward idle while the host clock sits high.
            if (state == ST_FWD_IDLE && hclk) begin
                pp_mode <= (mode == ECPPH_MODE_ECP);
            end
        end
    end

    // Output pins: push-pull drives both levels; open-collector drives only low.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            port_data_lines_out <= 8'h00;
            port_data_lines_oe  <= 1'b0;
            host_clk_out        <= RST_HOST_CLK;
            host_clk_oe         <= 1'b0;
            host_ack_line_out   <= RST_HOST_ACK;
            host_ack_line_oe    <= 1'b1;
            periph_req          <= 1'b0;
        end else begin
            port_data_lines_out <= next_obyte.data;
            port_data_lines_oe  <= next_drv_data;
            host_clk_out        <= next_hclk;
            host_clk_oe         <= pp_mode | ~next_hclk;
            host_ack_line_out   <= next_hack;
            host_ack_line_oe    <= pp_mode | ~next_hack;
            periph_req          <= ~sync2[10];
        end
    end

endmodule : ecpph_host

// ### src/ecpph_pkg.sv
package ecpph_pkg;

    // System clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 20;

    // Handshake intervals in nanoseconds, as printed.
    localparam int T_SETUP_MAX_NS    = 60;
    localparam int T_MIN80_NS        = 80;
    localparam int T_STROBE_MAX_NS   = 200;
    localparam int T_RELEASE_MAX_NS  = 180;
    localparam int T_FILT_MIN_NS     = 75;
    localparam int T_FILT_MAX_NS     = 130;
    localparam int T_FIFO_SETUP_NS   = 600;
    localparam int T_FIFO_PULSE_NS   = 600;
    localparam int T_FIFO_HOLD_NS    = 450;
    localparam int T_FIFO_REARM_NS   = 680;
    localparam int T_FIFO_DHOLD_NS   = 80;

    // Cycle counts: least times round up, longest times round down.
    localparam int CYC_MIN80       = (T_MIN80_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_FILT        = (T_FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_FIFO_SETUP  = (T_FIFO_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_FIFO_PULSE  = (T_FIFO_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_FIFO_HOLD   = (T_FIFO_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_FIFO_REARM  = (T_FIFO_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_FIFO_DHOLD  = (T_FIFO_DHOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_RELEASE_MAX = T_RELEASE_MAX_NS / CLK_PERIOD_NS;

    // Counter width.
    localparam int CNT_W = 6;

    // Reset values of the host-driven lines.
    localparam logic RST_HOST_CLK = 1'b1;
    localparam logic RST_HOST_ACK = 1'b0;

    // Port operating modes.
    typedef enum logic [1:0] {
        ECPPH_MODE_COMPAT = 2'b00,
        ECPPH_MODE_FIFO   = 2'b01,
        ECPPH_MODE_ECP    = 2'b10
    } ecpph_mode_t;

    // Handshake sequencer states.
    typedef enum logic [3:0] {
        ST_FWD_IDLE   = 4'b0000,
        ST_FWD_SETUP  = 4'b0001,
        ST_FWD_CLKLOW = 4'b0010,
        ST_FWD_CLKHI  = 4'b0011,
        ST_FWD_DRAIN  = 4'b0100,
        ST_REV_IDLE   = 4'b0101,
        ST_REV_WAIT   = 4'b0110,
        ST_REV_ACKHI  = 4'b0111,
        ST_REV_ACKLO  = 4'b1000,
        ST_FF_SETUP   = 4'b1001,
        ST_FF_PULSE   = 4'b1010,
        ST_FF_HOLD    = 4'b1011,
        ST_FF_REARM   = 4'b1100
    } ecpph_state_t;

    // A byte with its command/data flag carried on the host-ack line.
    typedef struct packed {
        logic       cmd;
        logic [7:0] data;
    } ecpph_byte_t;

endpackage : ecpph_pkg

// ### verif/ecpph_host_asserts.sv
`timescale 1ns/1ns
module ecpph_host_asserts
    import ecpph_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire ecpph_mode_t mode,
    input wire logic        tx_ready,
    input wire logic        rev_req,
    input wire logic        rx_room,
    input wire logic        rx_tc,
    input wire logic        busy_in,
    input wire logic        periph_clk_in,
    input wire logic [7:0]  port_data_lines_out,
    input wire logic        host_clk_out,
    input wire logic        host_clk_oe,
    input wire logic        host_ack_line_out
);
    logic [5:0] lo_cnt;
    logic [5:0] bz_cnt;
    wire        ecp = (mode == ECPPH_MODE_ECP);
    wire        fifo = (mode == ECPPH_MODE_FIFO);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Count strobe-low cycles and cycles since busy fell; both saturate.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lo_cnt <= 6'h00;
            bz_cnt <= 6'h3F;
        end else begin
            lo_cnt <= host_clk_out ? 6'h00 : lo_cnt + {5'h00, lo_cnt != 6'h3F};
            bz_cnt <= $fell(busy_in) ? 6'h00 : bz_cnt + {5'h00, bz_cnt != 6'h3F};
        end
    end
    a_strobe_follow: assert property (ecp && tx_ready |=> $fell(host_clk_out))
        else $error("host clock did not fall one cycle after data was set");
    a_strobe_gap: assert property (ecp && $fell(busy_in) |-> ##1 host_clk_out [*4])
        else $error("host clock fell too soon after busy fell");
    a_release_window: assert property (ecp && $rose(busy_in) && !host_clk_out
        |-> !host_clk_out [*4] ##[1:13] host_clk_out) else $error("host clock release out of window");
    a_data_hold: assert property (ecp && $fell(busy_in)
        |-> ($stable(port_data_lines_out) && $stable(host_ack_line_out)) [*5])
        else $error("data or command line changed too soon after busy fell");
    a_ack_rise_min: assert property (ecp && $fell(periph_clk_in) && !host_ack_line_out
        |-> !host_ack_line_out [*5]) else $error("host ack rose too soon");
    a_ack_rise_max: assert property (ecp && $fell(periph_clk_in) && rx_room && !rx_tc
        |-> ##[4:16] host_ack_line_out) else $error("host ack did not rise in time");
    a_stall_hold: assert property (ecp && rev_req && !host_ack_line_out && (!rx_room || rx_tc)
        |=> !host_ack_line_out) else $error("host ack rose while the sink was full");
    a_ack_fall_window: assert property (ecp && $rose(periph_clk_in) && host_ack_line_out
        |-> host_ack_line_out [*4] ##[1:13] !host_ack_line_out) else $error("host ack fall out of window");
    a_fifo_pulse: assert property (fifo && $rose(host_clk_out) |-> lo_cnt >= 6'h1E)
        else $error("strobe pulse too short");
    a_fifo_rearm: assert property (fifo && $fell(host_clk_out) |-> bz_cnt >= 6'h21)
        else $error("strobe came too soon after busy fell");
    a_open_drain: assert property (!ecp && $past(mode) != ECPPH_MODE_ECP
        && $past(mode, 2) != ECPPH_MODE_ECP && host_clk_oe |-> !host_clk_out)
        else $error("host clock driven high in open-collector mode");
    cover property (fifo && $rose(host_clk_out));
    cover property (ecp && $rose(host_clk_out));
    cover property (ecp && $rose(host_ack_line_out));
endmodule : ecpph_host_asserts

// ### verif/ecpph_periph_model.sv
`timescale 1ns/1ns
module ecpph_periph_model (
    input  wire logic       clk_sys,
    input  wire logic       host_clk,
    input  wire logic       host_ack,
    input  wire logic [7:0] data_in,
    input  wire logic [3:0] dly,
    input  wire logic       send_en,
    input  wire logic [7:0] send_byte,
    output logic            busy,
    output logic            pclk,
    output logic [7:0]      data_out,
    output logic [7:0]      got,
    output logic [7:0]      n_got
);
    // Idle levels of both directions.
    initial begin
        busy = 1'b0;
        pclk = 1'b1;
        data_out = 8'h00;
        got = 8'h00;
        n_got = 8'h00;
    end
    // Forward and FIFO: answer the host clock with busy, take data on its rise.
    always begin
        @(negedge host_clk);
        repeat (dly) @(posedge clk_sys);
        busy <= 1'b1;
        @(posedge host_clk);
        got <= data_in;
        n_got <= n_got + 8'h01;
        repeat (dly) @(posedge clk_sys);
        busy <= 1'b0;
    end
    // Reverse: offer a byte while the host holds its ack low, then scramble the lines.
    always begin
        @(posedge clk_sys);
        if (send_en && !host_ack) begin
            data_out <= send_byte;
            @(posedge clk_sys);
            pclk <= 1'b0;
            @(posedge host_ack);
            repeat (dly) @(posedge clk_sys);
            pclk <= 1'b1;
            @(negedge host_ack);
            @(posedge clk_sys);
            data_out <= ~send_byte;
        end
    end
endmodule : ecpph_periph_model

// ### verif/ecpph_host_bench.sv
`timescale 1ns/1ns
module ecpph_host_bench
    import ecpph_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    ecpph_mode_t mode = ECPPH_MODE_COMPAT;
    logic        tx_valid = 1'b0;
    ecpph_byte_t tx_byte = 9'h000;
    logic        rev_req = 1'b0;
    logic        rx_room = 1'b1;
    logic        rx_tc = 1'b0;
    logic        req_n = 1'b1;
    logic [3:0]  dly = 4'h1;
    logic        send_en = 1'b0;
    logic [7:0]  send_byte = 8'h00;
    logic        tx_ready, rx_valid, periph_req, busy, pclk, pd_oe, hc_out, hc_oe, ha_out, ha_oe;
    logic [7:0]  rx_data, data_out, got, n_got, pd_out;
    int          mismatches = 0;
    int          comparisons = 0;
    // Control lines are pulled up; data shows whoever drives it.
    wire         hclk_w = hc_oe ? hc_out : 1'b1;
    wire         ack_w = ha_oe ? ha_out : 1'b1;
    wire [7:0]   data_w = pd_oe ? pd_out : data_out;
    wire [3:0]   evt = {hclk_w & ~busy, periph_req, rx_valid, tx_ready};
    always #10 clk_sys = ~clk_sys;
    ecpph_host DUT (.clk_sys(clk_sys), .rst(rst), .mode(mode), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready), .rev_req(rev_req), .rx_room(rx_room),
        .rx_tc(rx_tc), .rx_valid(rx_valid), .rx_data(rx_data), .periph_req(periph_req),
        .busy_in(busy), .periph_clk_in(pclk), .periph_req_n_in(req_n),
        .port_data_lines_in(data_w), .port_data_lines_out(pd_out), .port_data_lines_oe(pd_oe),
        .host_clk_out(hc_out), .host_clk_oe(hc_oe), .host_ack_line_out(ha_out),
        .host_ack_line_oe(ha_oe));
    ecpph_periph_model u_periph (.clk_sys(clk_sys), .host_clk(hclk_w), .host_ack(ack_w),
        .data_in(data_w), .dly(dly), .send_en(send_en), .send_byte(send_byte), .busy(busy),
        .pclk(pclk), .data_out(data_out), .got(got), .n_got(n_got));
    task automatic give_verdict;
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    // Waits for one event bit; running out ends the run.
    task automatic wait_on(input int sel);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (evt[sel] !== 1'b1 && n < 600);
        if (n >= 600) begin
            check(1'b0, "wait ran out");
            give_verdict();
        end
    endtask : wait_on
    // Offers one byte, checks the lines just after it is taken, then the delivery.
    task automatic send(input ecpph_byte_t b);
        logic [7:0] k;
        k = n_got;
        tx_byte <= b;
        tx_valid <= 1'b1;
        wait_on(0);
        tx_valid <= 1'b0;
        @(posedge clk_sys);
        check(pd_out === b.data && pd_oe === 1'b1, "data lines wrong");
        check(hc_out === (mode != ECPPH_MODE_ECP), "strobe moment wrong");
        if (mode == ECPPH_MODE_ECP) check(ha_out === b.cmd, "command flag wrong");
        for (int i = 0; i < 600 && n_got === k; i++) @(posedge clk_sys);
        check(n_got !== k && got === b.data, "peripheral got wrong byte");
        wait_on(3);
    endtask : send
    task automatic t_reset;
        check(hc_out === 1'b1 && hc_oe === 1'b0 && ha_out === 1'b0, "idle lines wrong");
        check(ha_oe === 1'b1 && pd_oe === 1'b0, "idle drivers wrong");
        check(tx_ready === 1'b0 && rx_valid === 1'b0, "strobes active after reset");
    endtask : t_reset
    task automatic t_fifo;
        mode <= ECPPH_MODE_FIFO;
        dly <= 4'h8;
        repeat (4) @(posedge clk_sys);
        send(9'h03C);
        send(9'h0C3);
    endtask : t_fifo
    task automatic t_ecp;
        mode <= ECPPH_MODE_ECP;
        dly <= 4'h1;
        // The last FIFO hold must run out before forward idle latches push-pull drivers.
        repeat (40) @(posedge clk_sys);
        check(hc_oe === 1'b1 && hc_out === 1'b1, "not push-pull in extended mode");
        send(9'h1A5);
        dly <= 4'h8;
        send(9'h05A);
    endtask : t_ecp
    task automatic t_req;
        req_n <= 1'b0;
        wait_on(2);
        req_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check(periph_req === 1'b0, "request flag stuck");
    endtask : t_req
    // Reverse transfers with a full sink, then terminal count, then free flow.
    task automatic t_rev;
        rx_room <= 1'b0;
        rev_req <= 1'b1;
        send_byte <= 8'h5A;
        repeat (8) @(posedge clk_sys);
        send_en <= 1'b1;
        repeat (40) @(posedge clk_sys);
        check(ha_out === 1'b0 && pd_oe === 1'b0, "no stall on full sink");
        rx_room <= 1'b1;
        rx_tc <= 1'b1;
        repeat (20) @(posedge clk_sys);
        check(ha_out === 1'b0, "no stall on terminal count");
        rx_tc <= 1'b0;
        wait_on(1);
        check(rx_data === 8'h5A, "first reverse byte wrong");
        send_byte <= 8'hA7;
        wait_on(1);
        check(rx_data === 8'hA7, "second reverse byte wrong");
        send_en <= 1'b0;
    endtask : t_rev
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_fifo();
        t_ecp();
        t_req();
        t_rev();
        give_verdict();
    end
endmodule : ecpph_host_bench
bind ecpph_host ecpph_host_asserts u_chk (.clk_sys(clk_sys), .rst(rst), .mode(mode),
    .tx_ready(tx_ready), .rev_req(rev_req), .rx_room(rx_room), .rx_tc(rx_tc),
    .busy_in(busy_in), .periph_clk_in(periph_clk_in),
    .port_data_lines_out(port_data_lines_out), .host_clk_out(host_clk_out),
    .host_clk_oe(host_clk_oe), .host_ack_line_out(host_ack_line_out));
